// *** logic/iopw_pkg.sv ***
// Constants and types for the I/O port register window.
package iopw_pkg;
   localparam logic [7:0] OFF_A_IN    = 8'h00;
   localparam logic [7:0] OFF_B_IN    = 8'h01;
   localparam logic [7:0] OFF_A_MODE  = 8'h02;
   localparam logic [7:0] OFF_B_MODE  = 8'h03;
   localparam logic [7:0] OFF_A_OUT   = 8'h04;
   localparam logic [7:0] OFF_B_OUT   = 8'h05;
   localparam logic [7:0] OFF_A_DIR   = 8'h06;
   localparam logic [7:0] OFF_B_DIR   = 8'h07;
   localparam logic [7:0] OFF_A_DRV   = 8'h08;
   localparam logic [7:0] OFF_B_DRV   = 8'h09;
   localparam logic [7:0] OFF_A_IMC   = 8'h0a;
   localparam logic [7:0] OFF_B_IMC   = 8'h0b;
   localparam logic [7:0] OFF_A_OES   = 8'h0c;
   localparam logic [7:0] OFF_C_IN    = 8'h10;
   localparam logic [7:0] OFF_D_IN    = 8'h11;
   localparam logic [7:0] OFF_C_OUT   = 8'h12;
   localparam logic [7:0] OFF_D_OUT   = 8'h13;
   localparam logic [7:0] OFF_C_DIR   = 8'h14;
   localparam logic [7:0] OFF_D_DIR   = 8'h15;
   localparam logic [7:0] OFF_C_DRV   = 8'h16;
   localparam logic [7:0] OFF_C_IMC   = 8'h18;
   localparam logic [7:0] OFF_C_OES   = 8'h1a;
   localparam logic [7:0] OFF_D_OES   = 8'h1b;
   localparam logic [7:0] OFF_OMC_AB  = 8'h20;
   localparam logic [7:0] OFF_OMC_BC  = 8'h21;
   localparam logic [7:0] OFF_MASK_AB = 8'h22;
   localparam logic [7:0] OFF_MASK_BC = 8'h23;
   localparam logic [7:0] OFF_PWR0    = 8'hb0;
   localparam logic [7:0] OFF_PWR2    = 8'hb4;
   localparam logic [7:0] OFF_MAINPR  = 8'hc0;
   localparam logic [7:0] OFF_SECPR   = 8'hc2;
   localparam logic [7:0] OFF_TEST    = 8'hc7;
   localparam logic [7:0] OFF_PAGE    = 8'he0;
   localparam logic [7:0] OFF_MAP     = 8'he2;
   localparam logic [7:0] RST_BYTE    = 8'h00;
   // Base of the register window as upper host address byte.
   localparam logic [7:0] RST_WIN_BASE = 8'hff;
   // Memory-space map field positions.
   localparam int MAP_SRAM_CODE  = 0;
   localparam int MAP_MAIN_CODE  = 2;
   localparam int MAP_EE_CODE    = 3;
   localparam int MAP_MAIN_DATA  = 4;
   localparam int MAP_EE_DATA    = 5;
   // Sector select decode uses 16-Kbyte main and 8-Kbyte EEPROM sectors.
   localparam logic [7:0] MAIN_BASE_PAGE = 8'h00;
   localparam logic [7:0] EE_BASE_PAGE   = 8'h01;
   localparam logic [7:0] SRAM_HI_BYTE   = 8'hf0;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       prog_space;
      logic [15:0] addr;
      logic [7:0] page;
      logic [7:0] wdata;
   } iopw_req_t;

   typedef struct packed {
      logic [7:0] main_flash;
      logic [3:0] eeprom;
      logic       sram;
      logic       window;
   } iopw_sel_t;
endpackage

// *** logic/iopw_port_cell.sv ***
// One 8-bit I/O port: control registers and pin driver for a single port.
`timescale 1ns/1ps
module iopw_port_cell
   import iopw_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rstn,
   // Register writes.
   input  wire logic       we_out,
   input  wire logic       we_dir,
   input  wire logic       we_drv,
   input  wire logic       we_mode,
   input  wire logic [7:0] wdata,
   // Address nibble source and pin.
   input  wire logic [7:0] addr_lo,
   input  wire logic [7:0] pin_sync,
   // State and pin drive.
   output logic      [7:0] out_data,
   output logic      [7:0] dir,
   output logic      [7:0] drv,
   output logic      [7:0] mode,
   output logic      [7:0] pin_o,
   output logic      [7:0] pin_oe
);
   logic [7:0] next_out_data;
   logic [7:0] next_dir;
   logic [7:0] next_drv;
   logic [7:0] next_mode;
   logic [7:0] next_pin_o;
   logic [7:0] next_pin_oe;

   always_comb begin
      next_out_data = we_out  ? wdata : out_data;
      next_dir      = we_dir  ? wdata : dir;
      next_drv      = we_drv  ? wdata : drv;
      next_mode     = we_mode ? wdata : mode;
      for (int i = 0; i < 8; i++) begin
         if (mode[i]) begin
            // Pin i shows bit i of the latched address.
            next_pin_o[i]  = addr_lo[i];
            next_pin_oe[i] = 1'b1;
         end else begin
            // Open drain only drives a low level.
            next_pin_o[i]  = drv[i] ? 1'b0 : out_data[i];
            next_pin_oe[i] = dir[i] & (~drv[i] | ~out_data[i]);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         out_data <= RST_BYTE;
         dir      <= RST_BYTE;
         drv      <= RST_BYTE;
         mode     <= RST_BYTE;
         pin_o    <= RST_BYTE;
         pin_oe   <= RST_BYTE;
      end else begin
         out_data <= next_out_data;
         dir      <= next_dir;
         drv      <= next_drv;
         mode     <= next_mode;
         pin_o    <= next_pin_o;
         pin_oe   <= next_pin_oe;
      end
   end

   property p_oe_off;
      @(posedge clk) disable iff (!rstn)
         (!mode[0] && !dir[0]) |=> !pin_oe[0];
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("input pin is driven");
endmodule // iopw_port_cell

// *** logic/iopw_window.sv ***
// Register window decode, port registers and memory selects.
`timescale 1ns/1ps
module iopw_window
   import iopw_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rstn,
   // Host bus, sampled on clk.
   input  wire logic        host_wr,
   input  wire logic        host_rd,
   input  wire logic        host_prog_space,
   input  wire logic [15:0] host_addr,
   input  wire logic [7:0]  host_wdata,
   output logic      [7:0]  host_rdata,
   // Status from the rest of the device.
   input  wire logic [7:0]  main_flash_protect,
   input  wire logic [3:0]  eeprom_protect,
   input  wire logic        security_bit,
   input  wire logic [7:0]  input_cells_a,
   input  wire logic [7:0]  input_cells_b,
   input  wire logic [7:0]  input_cells_c,
   input  wire logic [15:0] cell_outputs,
   // Port pins.
   input  wire logic [7:0]  port_a_i,
   input  wire logic [7:0]  port_b_i,
   input  wire logic [7:0]  port_c_i,
   input  wire logic [7:0]  port_d_i,
   output logic      [7:0]  port_a_o,
   output logic      [7:0]  port_a_oe,
   output logic      [7:0]  port_b_o,
   output logic      [7:0]  port_b_oe,
   output logic      [7:0]  port_c_o,
   output logic      [7:0]  port_c_oe,
   output logic      [7:0]  port_d_o,
   output logic      [7:0]  port_d_oe,
   // Output cell loads.
   output logic      [15:0] cell_load_data,
   output logic      [15:0] cell_load_en,
   // Configuration and memory selects.
   output logic      [7:0]  power_control_zero,
   output logic      [7:0]  power_control_two,
   output logic      [7:0]  test_port_enable,
   output logic      [7:0]  page_extension,
   output logic      [7:0]  memory_space_map,
   output logic      [7:0]  main_flash_sel,
   output logic      [3:0]  eeprom_sel,
   output logic             sram_sel
);
   logic [7:0] a_sync1, a_sync2, b_sync1, b_sync2;
   logic [7:0] c_sync1, c_sync2, d_sync1, d_sync2;
   logic [7:0] out_a, out_b, out_c, out_d;
   logic [7:0] dir_a, dir_b, dir_c, dir_d;
   logic [7:0] drv_a, drv_b, drv_c, drv_d;
   logic [7:0] mode_a, mode_b, mode_c, mode_d;
   logic [7:0] mask_ab, mask_bc;
   logic [7:0] next_mask_ab, next_mask_bc;
   logic [7:0] next_pwr0, next_pwr2, next_test, next_page, next_map;
   logic [7:0] next_rdata;
   logic [15:0] next_load_data, next_load_en;
   logic [7:0] addr_latch, next_addr_latch;
   logic [7:0] addr_nib;
   iopw_sel_t  next_sel;
   iopw_req_t  req;
   logic       wr_win;
   logic       rd_win;
   logic [7:0] off;

   function automatic logic wr_at(input logic [7:0] o);
      wr_at = wr_win && (off == o);
   endfunction

   function automatic logic map_bit(input logic [7:0] m, input int c, input int d,
                                    input logic prog);
      map_bit = prog ? m[c] : (d < 0 ? 1'b1 : m[d]);
   endfunction

   assign req = '{wr: host_wr, rd: host_rd, prog_space: host_prog_space,
                  addr: host_addr, page: page_extension, wdata: host_wdata};
   assign off    = req.addr[7:0];
   assign wr_win = req.wr && (req.addr[15:8] == RST_WIN_BASE);
   assign rd_win = req.rd && (req.addr[15:8] == RST_WIN_BASE);

   // In address mode, ports A and B carry a3-a0 on the low half, a7-a4 on the high half.
   assign addr_nib = addr_latch;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         a_sync1 <= RST_BYTE; a_sync2 <= RST_BYTE;
         b_sync1 <= RST_BYTE; b_sync2 <= RST_BYTE;
         c_sync1 <= RST_BYTE; c_sync2 <= RST_BYTE;
         d_sync1 <= RST_BYTE; d_sync2 <= RST_BYTE;
      end else begin
         a_sync1 <= port_a_i; a_sync2 <= a_sync1;
         b_sync1 <= port_b_i; b_sync2 <= b_sync1;
         c_sync1 <= port_c_i; c_sync2 <= c_sync1;
         d_sync1 <= port_d_i; d_sync2 <= d_sync1;
      end
   end

   iopw_port_cell u_port_a (.clk(clk), .rstn(rstn), .we_out(wr_at(OFF_A_OUT)),
      .we_dir(wr_at(OFF_A_DIR)), .we_drv(wr_at(OFF_A_DRV)), .we_mode(wr_at(OFF_A_MODE)),
      .wdata(req.wdata), .addr_lo(addr_nib), .pin_sync(a_sync2), .out_data(out_a),
      .dir(dir_a), .drv(drv_a), .mode(mode_a), .pin_o(port_a_o), .pin_oe(port_a_oe));
   iopw_port_cell u_port_b (.clk(clk), .rstn(rstn), .we_out(wr_at(OFF_B_OUT)),
      .we_dir(wr_at(OFF_B_DIR)), .we_drv(wr_at(OFF_B_DRV)), .we_mode(wr_at(OFF_B_MODE)),
      .wdata(req.wdata), .addr_lo(addr_nib), .pin_sync(b_sync2), .out_data(out_b),
      .dir(dir_b), .drv(drv_b), .mode(mode_b), .pin_o(port_b_o), .pin_oe(port_b_oe));
   // Ports C and D have no address mode; port D has no drive-type register.
   iopw_port_cell u_port_c (.clk(clk), .rstn(rstn), .we_out(wr_at(OFF_C_OUT)),
      .we_dir(wr_at(OFF_C_DIR)), .we_drv(wr_at(OFF_C_DRV)), .we_mode(1'b0),
      .wdata(req.wdata), .addr_lo(addr_nib), .pin_sync(c_sync2), .out_data(out_c),
      .dir(dir_c), .drv(drv_c), .mode(mode_c), .pin_o(port_c_o), .pin_oe(port_c_oe));
   iopw_port_cell u_port_d (.clk(clk), .rstn(rstn), .we_out(wr_at(OFF_D_OUT)),
      .we_dir(wr_at(OFF_D_DIR)), .we_drv(1'b0), .we_mode(1'b0),
      .wdata(req.wdata), .addr_lo(addr_nib), .pin_sync(d_sync2), .out_data(out_d),
      .dir(dir_d), .drv(drv_d), .mode(mode_d), .pin_o(port_d_o), .pin_oe(port_d_oe));

   always_comb begin
      next_mask_ab = wr_at(OFF_MASK_AB) ? req.wdata : mask_ab;
      next_mask_bc = wr_at(OFF_MASK_BC) ? req.wdata : mask_bc;
      next_pwr0 = wr_at(OFF_PWR0) ? req.wdata : power_control_zero;
      next_pwr2 = wr_at(OFF_PWR2) ? req.wdata : power_control_two;
      next_test = wr_at(OFF_TEST) ? req.wdata : test_port_enable;
      next_page = wr_at(OFF_PAGE) ? req.wdata : page_extension;
      next_map  = wr_at(OFF_MAP)  ? req.wdata : memory_space_map;
      next_addr_latch = (req.rd || req.wr) ? req.addr[7:0] : addr_latch;
      next_load_data = {req.wdata, req.wdata};
      next_load_en   = {({8{wr_at(OFF_OMC_BC)}} & ~mask_bc),
                        ({8{wr_at(OFF_OMC_AB)}} & ~mask_ab)};
   end

   always_comb begin
      next_rdata = RST_BYTE;
      if (rd_win) begin
         unique case (off)
            OFF_A_IN:    next_rdata = a_sync2;
            OFF_B_IN:    next_rdata = b_sync2;
            OFF_C_IN:    next_rdata = c_sync2;
            OFF_D_IN:    next_rdata = d_sync2;
            OFF_A_MODE:  next_rdata = mode_a;
            OFF_B_MODE:  next_rdata = mode_b;
            OFF_A_OUT:   next_rdata = out_a;
            OFF_B_OUT:   next_rdata = out_b;
            OFF_C_OUT:   next_rdata = out_c;
            OFF_D_OUT:   next_rdata = out_d;
            OFF_A_DIR:   next_rdata = dir_a;
            OFF_B_DIR:   next_rdata = dir_b;
            OFF_C_DIR:   next_rdata = dir_c;
            OFF_D_DIR:   next_rdata = dir_d;
            OFF_A_DRV:   next_rdata = drv_a;
            OFF_B_DRV:   next_rdata = drv_b;
            OFF_C_DRV:   next_rdata = drv_c;
            OFF_A_IMC:   next_rdata = input_cells_a;
            OFF_B_IMC:   next_rdata = input_cells_b;
            OFF_C_IMC:   next_rdata = input_cells_c;
            OFF_A_OES:   next_rdata = port_a_oe;
            OFF_C_OES:   next_rdata = port_c_oe;
            OFF_D_OES:   next_rdata = port_d_oe;
            OFF_OMC_AB:  next_rdata = cell_outputs[7:0];
            OFF_OMC_BC:  next_rdata = cell_outputs[15:8];
            OFF_MASK_AB: next_rdata = mask_ab;
            OFF_MASK_BC: next_rdata = mask_bc;
            OFF_PWR0:    next_rdata = power_control_zero;
            OFF_PWR2:    next_rdata = power_control_two;
            OFF_MAINPR:  next_rdata = main_flash_protect;
            OFF_SECPR:   next_rdata = {security_bit, 3'b000, eeprom_protect};
            OFF_TEST:    next_rdata = test_port_enable;
            OFF_PAGE:    next_rdata = page_extension;
            OFF_MAP:     next_rdata = memory_space_map;
            default:     next_rdata = RST_BYTE;
         endcase
      end
   end

   // Sector selects: 16-Kbyte main sectors on page 0, 8-Kbyte EEPROM on page 1.
   always_comb begin
      next_sel = '0;
      if ((req.rd || req.wr) && req.addr[15:8] != RST_WIN_BASE) begin
         if (req.addr[15:8] >= SRAM_HI_BYTE) begin
            next_sel.sram = map_bit(memory_space_map, MAP_SRAM_CODE, -1, req.prog_space);
         end else if (req.page == MAIN_BASE_PAGE) begin
            if (map_bit(memory_space_map, MAP_MAIN_CODE, MAP_MAIN_DATA, req.prog_space))
               next_sel.main_flash[req.addr[15:14] + (req.addr[15] ? 3'd4 : 3'd0)] = 1'b1;
         end else if (req.page == EE_BASE_PAGE && !req.addr[15]) begin
            if (map_bit(memory_space_map, MAP_EE_CODE, MAP_EE_DATA, req.prog_space))
               next_sel.eeprom[req.addr[14:13]] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         mask_ab            <= RST_BYTE;
         mask_bc            <= RST_BYTE;
         power_control_zero <= RST_BYTE;
         power_control_two  <= RST_BYTE;
         test_port_enable   <= RST_BYTE;
         page_extension     <= RST_BYTE;
         memory_space_map   <= RST_BYTE;
         addr_latch         <= RST_BYTE;
         host_rdata         <= RST_BYTE;
         cell_load_data     <= '0;
         cell_load_en       <= '0;
         main_flash_sel     <= '0;
         eeprom_sel         <= '0;
         sram_sel           <= 1'b0;
      end else begin
         mask_ab            <= next_mask_ab;
         mask_bc            <= next_mask_bc;
         power_control_zero <= next_pwr0;
         power_control_two  <= next_pwr2;
         test_port_enable   <= next_test;
         page_extension     <= next_page;
         memory_space_map   <= next_map;
         addr_latch         <= next_addr_latch;
         host_rdata         <= next_rdata;
         cell_load_data     <= next_load_data;
         cell_load_en       <= next_load_en;
         main_flash_sel     <= next_sel.main_flash;
         eeprom_sel         <= next_sel.eeprom;
         sram_sel           <= next_sel.sram;
      end
   end

   property p_mask_blocks;
      @(posedge clk) disable iff (!rstn)
         (wr_win && off == OFF_OMC_AB && mask_ab[0]) |=> !cell_load_en[0];
   endproperty
   a_mask_blocks: assert property (p_mask_blocks) else $error("masked cell loaded");

   property p_ab_load;
      @(posedge clk) disable iff (!rstn)
         (wr_win && off == OFF_OMC_AB && mask_ab == 8'h00) |=> (cell_load_en[7:0] == 8'hff);
   endproperty
   a_ab_load: assert property (p_ab_load) else $error("AB load missing");

   property p_bc_load;
      @(posedge clk) disable iff (!rstn)
         (wr_win && off == OFF_OMC_BC && mask_bc == 8'h00) |=> (cell_load_en[15:8] == 8'hff);
   endproperty
   a_bc_load: assert property (p_bc_load) else $error("BC load missing");

   property p_unmapped_zero;
      @(posedge clk) disable iff (!rstn)
         (rd_win && off == 8'hff) |=> (host_rdata == 8'h00);
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read");

   property p_main_ro;
      @(posedge clk) disable iff (!rstn)
         (rd_win && off == OFF_MAINPR) |=> (host_rdata == $past(main_flash_protect));
   endproperty
   a_main_ro: assert property (p_main_ro) else $error("protect read wrong");

   property p_sec_ro;
      @(posedge clk) disable iff (!rstn)
         (rd_win && off == OFF_SECPR) |=> (host_rdata[3:0] == $past(eeprom_protect));
   endproperty
   a_sec_ro: assert property (p_sec_ro) else $error("security read wrong");

   property p_page_store;
      @(posedge clk) disable iff (!rstn)
         (wr_win && off == OFF_PAGE) |=> (page_extension == $past(req.wdata));
   endproperty
   a_page_store: assert property (p_page_store) else $error("page not stored");

   property p_out_drive;
      @(posedge clk) disable iff (!rstn)
         (wr_win && off == OFF_C_OUT && drv_c == 8'h00) |=> ##1 (port_c_o == out_c);
   endproperty
   a_out_drive: assert property (p_out_drive) else $error("output not driven");

   property p_pin_in;
      @(posedge clk) disable iff (!rstn)
         (rd_win && off == OFF_D_IN) |=> (host_rdata == $past(d_sync2));
   endproperty
   a_pin_in: assert property (p_pin_in) else $error("pin read wrong");

   property p_window_only;
      @(posedge clk) disable iff (!rstn)
         (host_wr && host_addr[15:8] != RST_WIN_BASE) |=> ($stable(page_extension));
   endproperty
   a_window_only: assert property (p_window_only) else $error("write outside window");

   property p_mode_store;
      @(posedge clk) disable iff (!rstn)
         (wr_win && off == OFF_A_MODE) |=> (mode_a == $past(req.wdata));
   endproperty
   a_mode_store: assert property (p_mode_store) else $error("mode not stored");

   property p_out_store;
      @(posedge clk) disable iff (!rstn)
         (wr_win && off == OFF_D_OUT) |=> (out_d == $past(req.wdata));
   endproperty
   a_out_store: assert property (p_out_store) else $error("output not stored");

   property p_dir_store;
      @(posedge clk) disable iff (!rstn)
         (wr_win && off == OFF_C_DIR) |=> (dir_c == $past(req.wdata));
   endproperty
   a_dir_store: assert property (p_dir_store) else $error("direction not stored");

   property p_drv_store;
      @(posedge clk) disable iff (!rstn)
         (wr_win && off == OFF_A_DRV) |=> (drv_a == $past(req.wdata));
   endproperty
   a_drv_store: assert property (p_drv_store) else $error("drive type not stored");

   property p_oes_read;
      @(posedge clk) disable iff (!rstn)
         (rd_win && off == OFF_C_OES) |=> (host_rdata == $past(port_c_oe));
   endproperty
   a_oes_read: assert property (p_oes_read) else $error("enable status wrong");

   property p_load_idle;
      @(posedge clk) disable iff (!rstn)
         !wr_win |=> (cell_load_en == 16'h0000);
   endproperty
   a_load_idle: assert property (p_load_idle) else $error("stray cell load");

   property p_map_store;
      @(posedge clk) disable iff (!rstn)
         (wr_win && off == OFF_MAP) |=> (memory_space_map == $past(req.wdata));
   endproperty
   a_map_store: assert property (p_map_store) else $error("map not stored");

   property p_addr_out;
      @(posedge clk) disable iff (!rstn)
         (mode_b == 8'hff) |=> (port_b_o == $past(addr_latch));
   endproperty
   a_addr_out: assert property (p_addr_out) else $error("address not driven");

   property p_sram_data;
      @(posedge clk) disable iff (!rstn)
         (host_rd && !host_prog_space && host_addr[15:12] == 4'hf &&
          host_addr[15:8] != RST_WIN_BASE) |=> sram_sel;
   endproperty
   a_sram_data: assert property (p_sram_data) else $error("data SRAM not selected");

   property p_rdata_idle;
      @(posedge clk) disable iff (!rstn)
         !rd_win |=> (host_rdata == RST_BYTE);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

   c_page_wr:  cover property (@(posedge clk) wr_win && off == OFF_PAGE);
   c_ab_load:  cover property (@(posedge clk) wr_win && off == OFF_OMC_AB && mask_ab != 8'h00);
   c_addr_out: cover property (@(posedge clk) mode_a != 8'h00);
   c_eeprom:   cover property (@(posedge clk) eeprom_sel != 4'h0);
endmodule // iopw_window

// *** testbench/iopw_pin_world.sv ***
// Pin-side model: an external driver and a pull-up on every port line.
`timescale 1ns/1ps
module iopw_pin_world (
   // Drive from the device.
   input  wire logic [31:0] pin_o,
   input  wire logic [31:0] pin_oe,
   // External driver.
   input  wire logic [31:0] ext_v,
   input  wire logic [31:0] ext_en,
   // Resolved line levels.
   output logic      [31:0] pin
);
   // A line that nobody drives floats high through its pull-up.
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         pin[i] = pin_oe[i] ? pin_o[i] : (ext_en[i] ? ext_v[i] : 1'b1);
      end
   end
endmodule // iopw_pin_world

// *** testbench/testbench.sv ***
// Self-checking bench for the I/O port register window.
`timescale 1ns/1ps
module testbench;
   import iopw_pkg::*;
   logic        clk, rstn, host_wr, host_rd, host_prog_space, security_bit, sram_sel;
   logic [3:0]  eeprom_protect, eeprom_sel;
   logic [7:0]  host_wdata, host_rdata, main_flash_protect, main_flash_sel, rd_v;
   logic [7:0]  input_cells_a, input_cells_b, input_cells_c, page_extension;
   logic [7:0]  power_control_zero, power_control_two, test_port_enable, memory_space_map;
   logic [7:0]  port_a_i, port_b_i, port_c_i, port_d_i, port_a_o, port_b_o, port_c_o, port_d_o;
   logic [7:0]  port_a_oe, port_b_oe, port_c_oe, port_d_oe;
   logic [15:0] host_addr, cell_outputs, cell_load_data, cell_load_en, ld_d, ld_e;
   logic [31:0] ext_v, ext_en, pin;
   logic [12:0] sel_v;
   logic [7:0]  rw [20] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h12,
      8'h13, 8'h14, 8'h15, 8'h16, 8'h22, 8'h23, 8'hb0, 8'hb4, 8'hc7, 8'he0, 8'he2};
   int          n_errors, comparisons, cyc;

   iopw_window u_iopw_window (.*);
   iopw_pin_world u_iopw_pin_world (
      .pin_o ({port_d_o, port_c_o, port_b_o, port_a_o}),
      .pin_oe({port_d_oe, port_c_oe, port_b_oe, port_a_oe}),
      .ext_v (ext_v),
      .ext_en(ext_en),
      .pin   (pin)
   );
   assign {port_d_i, port_c_i, port_b_i, port_a_i} = pin;

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One host cycle; captures what the design answers one cycle after the request.
   task automatic acc(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
      host_wr <= w;
      host_rd <= r;
      host_addr <= a;
      host_wdata <= d;
      @(posedge clk);
      host_wr <= 1'b0;
      host_rd <= 1'b0;
      #1;
      rd_v = host_rdata;
      ld_d = cell_load_data;
      ld_e = cell_load_en;
      sel_v = {sram_sel, eeprom_sel, main_flash_sel};
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] o, input logic [7:0] d);
      acc(1'b1, 1'b0, {RST_WIN_BASE, o}, d);
   endtask

   task automatic rd(input logic [7:0] o, input logic [7:0] e);
      acc(1'b0, 1'b1, {RST_WIN_BASE, o}, 8'h00);
      chk($sformatf("rdata at %h", o), 16'(e), 16'(rd_v));
   endtask

   // Pins need one edge to update and two more to pass the synchroniser.
   task automatic settle;
      repeat (2) @(posedge clk);
   endtask

   task automatic complete_run;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         $display("MISMATCH run time expected below 3000 cycles seen %0d", cyc);
         complete_run();
      end
   end

   initial begin
      rstn = 1'b0;
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_prog_space = 1'b1;
      host_addr = 16'h0000;
      host_wdata = 8'h00;
      main_flash_protect = 8'h5a;
      eeprom_protect = 4'h9;
      security_bit = 1'b1;
      input_cells_a = 8'h11;
      input_cells_b = 8'h22;
      input_cells_c = 8'h33;
      cell_outputs = 16'hc33c;
      ext_v = 32'ha5c3_7e18;
      ext_en = 32'hffff_ffff;
      n_errors = 0;
      comparisons = 0;
      cyc = 0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      foreach (rw[i]) rd(rw[i], RST_BYTE);
      wr(OFF_OMC_AB, 8'h5a);
      chk("load en ab open", 16'h00ff, ld_e);
      wr(OFF_OMC_BC, 8'hc3);
      chk("load en bc open", 16'hff00, ld_e);
      foreach (rw[i]) begin
         wr(rw[i], 8'h5a ^ rw[i]);
         rd(rw[i], 8'h5a ^ rw[i]);
      end
      chk("page", 16'(8'h5a ^ OFF_PAGE), 16'(page_extension));
      chk("map", 16'(8'h5a ^ OFF_MAP), 16'(memory_space_map));
      chk("pwr0", 16'(8'h5a ^ OFF_PWR0), 16'(power_control_zero));
      chk("pwr2", 16'(8'h5a ^ OFF_PWR2), 16'(power_control_two));
      chk("test", 16'(8'h5a ^ OFF_TEST), 16'(test_port_enable));
      rd(OFF_D_IN, 8'he9);
      rd(OFF_D_OES, 8'h4f);
      chk("port d o", 16'h0049, 16'(port_d_o));
      foreach (rw[i]) wr(8'h5a, 8'hff);
      wr(OFF_MAINPR, 8'hff);
      wr(OFF_SECPR, 8'hff);
      rd(OFF_MAINPR, main_flash_protect);
      rd(OFF_SECPR, {security_bit, 3'b000, eeprom_protect});
      rd(OFF_A_IMC, input_cells_a);
      rd(8'h0d, 8'h00);
      rd(8'hff, 8'h00);
      acc(1'b1, 1'b0, 16'h12e0, 8'h77);
      rd(8'h5a, 8'h00);
      rd(OFF_PAGE, 8'h5a ^ OFF_PAGE);
      wr(OFF_A_MODE, 8'h00);
      wr(OFF_A_DRV, 8'h00);
      wr(OFF_A_DIR, 8'hf0);
      wr(OFF_A_OUT, 8'h96);
      settle();
      chk("port a oe", 16'h00f0, 16'(port_a_oe));
      chk("port a o", 16'h0009, 16'(port_a_o[7:4]));
      rd(OFF_A_IN, 8'h98);
      rd(OFF_A_OES, 8'hf0);
      wr(OFF_C_DRV, 8'hff);
      wr(OFF_C_DIR, 8'hff);
      wr(OFF_C_OUT, 8'h0f);
      settle();
      chk("port c oe", 16'h00f0, 16'(port_c_oe));
      rd(OFF_C_IN, 8'h03);
      rd(OFF_C_OES, 8'hf0);
      wr(OFF_B_MODE, 8'hff);
      acc(1'b0, 1'b1, 16'hff5a, 8'h00);
      settle();
      chk("port b address", 16'h005a, 16'(port_b_o));
      chk("port b oe", 16'h00ff, 16'(port_b_oe));
      wr(OFF_MASK_AB, 8'h0f);
      wr(OFF_MASK_BC, 8'hf0);
      wr(OFF_OMC_AB, 8'ha5);
      chk("load en ab", 16'h00f0, ld_e);
      chk("load data ab", 16'h00a5, 16'(ld_d[7:0]));
      wr(OFF_OMC_BC, 8'h3c);
      chk("load en bc", 16'h0f00, ld_e);
      chk("load data bc", 16'h003c, 16'(ld_d[15:8]));
      rd(OFF_OMC_AB, cell_outputs[7:0]);
      rd(OFF_OMC_BC, cell_outputs[15:8]);
      wr(OFF_MAP, 8'h3d);
      wr(OFF_PAGE, 8'h00);
      acc(1'b0, 1'b1, 16'h4000, 8'h00);
      chk("main select", 16'h0002, 16'(sel_v));
      wr(OFF_PAGE, 8'h01);
      acc(1'b0, 1'b1, 16'h2000, 8'h00);
      chk("eeprom select", 16'h0200, 16'(sel_v));
      acc(1'b0, 1'b1, 16'hf000, 8'h00);
      chk("sram select", 16'h1000, 16'(sel_v));
      host_prog_space <= 1'b0;
      wr(OFF_MAP, 8'h0d);
      acc(1'b0, 1'b1, 16'h2000, 8'h00);
      chk("eeprom data select", 16'h0000, 16'(sel_v));
      acc(1'b0, 1'b1, 16'hf000, 8'h00);
      chk("sram data select", 16'h1000, 16'(sel_v));
      complete_run();
   end
endmodule // testbench
